// ===== core/sfl_top.sv
// Function latch control of a PLL synthesizer behind its three-wire interface.
// Contract
// - Select code 10 loads function latch
// - Counter clear bit holds counters in reset
// - Soft sleep bit powers down at once
// - Chip-on low disables regardless of sleep
// - Power-down loads counters, pump hi-z, lock reset
// - Serial input keeps loading during power-down
// - Three-bit field selects monitor output
// - Fast lock only when enable bit set
// - Variant bit picks first or second mode
// - Mode one follows boost bit writes
// - Mode two clears boost after timeout
// - Timeout code field sets duration
// - Alternate current during fast lock, else main
// - Timeout counter runs only in mode two
// - Detector sense bit sets phase polarity
// - Pump hi-z bit tri-states pump output
// - Chip-on sequence; latches survive pin toggles
// - Strobe rise transfers 24 shifted bits
// - Words arrive most significant bit first
// - Select bits sit at positions one, zero
`timescale 1ns/10ps
module sfl_top
    import sfl_pkg::*;
(
    input wire logic i_clk_sys, // System clock, 100 MHz
    input wire logic i_reset, // Synchronous reset, active high
    input wire logic i_sclk, // Serial clock pin
    input wire logic i_sdata, // Serial data pin
    input wire logic i_load_strobe, // Load strobe pin
    input wire logic i_chip_on, // Chip-on pin, low disables
    input wire logic i_pfd_tick, // One pulse per detector cycle
    input wire logic i_lock_detect, // Digital lock detect level
    input wire logic i_ref_div_out, // Reference divider output
    input wire logic i_fb_div_out, // Feedback divider output
    output logic o_power_down, // Device powered down
    output logic o_counter_hold, // Reference and feedback counters held
    output logic o_timeout_load, // Timeout counter held in load state
    output logic o_lock_reset, // Lock detect logic reset
    output logic o_pump_hiz, // Charge pump output high impedance
    output logic [2:0] o_pump_current, // Charge pump current code
    output logic o_fast_lock, // Fast lock active
    output logic o_detector_sense, // Phase detector sense
    output logic [1:0] o_prescale_sel, // Prescaler select code
    output logic o_monitor_out, // Monitor output pin level
    output logic o_monitor_oe, // Monitor output enable
    output sfl_word_type o_ref_latch, // Reference counter latch
    output sfl_word_type o_fb_latch // Feedback counter latch
);
    `include "sfl_cfg.svh"

    typedef struct packed {
        logic [2:0] chip_on_s;
        logic chip_on;
        sfl_word_type func;
        sfl_word_type ref_w;
        sfl_word_type fb_w;
        sfl_count_type to_cnt;
        logic power_down;
        logic counter_hold;
        logic timeout_load;
        logic lock_reset;
        logic pump_hiz;
        logic [2:0] pump_current;
        logic fast_lock;
        logic detector_sense;
        logic [1:0] prescale_sel;
        logic monitor_out;
        logic monitor_oe;
    } sfl_top_state_type;

    sfl_top_state_type st_r;
    sfl_top_state_type st_nxt;

    sfl_word_if word_if ();

    // Cycle count for a timeout code; the step is a design constant
    function automatic sfl_count_type timeout_cycles(input logic [3:0] code);
        sfl_count_type c;
        c = {8'h00, code} + 12'h001;
        timeout_cycles = sfl_count_type'(c * `SFL_TO_STEP);
    endfunction

    // Reads the select pair at the bottom of a word
    function automatic logic [1:0] latch_select(input sfl_word_type w);
        latch_select = {w[`SFL_SEL_HI], w[`SFL_SEL_LO]};
    endfunction

    sfl_serial_rx u_rx (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_sclk(i_sclk),
        .i_sdata(i_sdata),
        .i_load_strobe(i_load_strobe),
        .word_if(word_if.src)
    );

    logic pd_now;
    logic qs_en;
    logic qs_var;
    logic boost;
    logic to_run;
    logic [2:0] mon_sel;
    logic mon_level;
    logic mon_oe;

    // Latch loading, power-down and fast-lock control
    always_comb begin
        st_nxt = st_r;
        pd_now = 1'b0;
        qs_en = 1'b0;
        qs_var = 1'b0;
        boost = 1'b0;
        to_run = 1'b0;
        mon_sel = 3'h0;
        mon_level = 1'b0;
        mon_oe = 1'b1;

        // Chip-on pin counts once sync stages two and three agree
        st_nxt.chip_on_s = {st_r.chip_on_s[1:0], i_chip_on};
        if (st_r.chip_on_s[1] == st_r.chip_on_s[2]) begin
            st_nxt.chip_on = st_r.chip_on_s[2];
        end

        // Words are routed by select code, even while powered down
        if (word_if.load) begin
            case (latch_select(word_if.word))
                `SFL_SEL_FUNC: begin
                    st_nxt.func = word_if.word;
                end
                `SFL_SEL_REF: begin
                    st_nxt.ref_w = word_if.word;
                end
                `SFL_SEL_FB: begin
                    st_nxt.fb_w = word_if.word;
                end
                default: begin
                    st_nxt.func = st_r.func;
                end
            endcase
        end

        // Pin low wins over the soft sleep bit; power-down clears no latch
        pd_now = !st_nxt.chip_on || st_nxt.func[`SFL_SOFT_SLEEP];
        qs_en = st_nxt.func[`SFL_QS_ENABLE];
        qs_var = st_nxt.func[`SFL_QS_VARIANT];
        boost = st_nxt.fb_w[`SFL_BOOST];
        to_run = qs_en && qs_var && boost && !pd_now;

        // Timeout counter: reloaded on a feedback write, held in load state while not running, else counts down on ticks
        if (!to_run || (word_if.load && latch_select(word_if.word) == `SFL_SEL_FB)) begin
            st_nxt.to_cnt = timeout_cycles(st_nxt.func[`SFL_TO_MSB:`SFL_TO_LSB]);
        end else if (i_pfd_tick) begin
            if (st_r.to_cnt <= 12'h001) begin
                // Expiry clears the boost bit in the feedback latch
                st_nxt.fb_w[`SFL_BOOST] = 1'b0;
                boost = 1'b0;
                st_nxt.to_cnt = timeout_cycles(st_nxt.func[`SFL_TO_MSB:`SFL_TO_LSB]);
            end else begin
                st_nxt.to_cnt = sfl_count_type'(st_r.to_cnt - 12'h001);
            end
        end

        // Mode one simply follows the boost bit as last written
        st_nxt.fast_lock = qs_en && boost && !pd_now;
        st_nxt.pump_current = st_nxt.fast_lock
            ? st_nxt.func[`SFL_ALT_MSB:`SFL_ALT_LSB]
            : st_nxt.func[`SFL_MAIN_MSB:`SFL_MAIN_LSB];

        // Power-down side effects and the plain function fields
        st_nxt.power_down = pd_now;
        st_nxt.counter_hold = pd_now || st_nxt.func[`SFL_CNT_CLEAR];
        st_nxt.timeout_load = !to_run;
        st_nxt.lock_reset = pd_now;
        st_nxt.pump_hiz = pd_now || st_nxt.func[`SFL_PUMP_HIZ];
        st_nxt.detector_sense = st_nxt.func[`SFL_DET_SENSE];
        st_nxt.prescale_sel = st_nxt.func[`SFL_PRE_MSB:`SFL_PRE_LSB];

        // Monitor source; open-drain lock mode drives only the low level
        mon_sel = st_nxt.func[`SFL_MON_MSB:`SFL_MON_LSB];
        case (mon_sel)
            `SFL_MON_LOW: begin
                mon_level = 1'b0;
            end
            `SFL_MON_LOCK: begin
                mon_level = i_lock_detect;
            end
            `SFL_MON_FB: begin
                mon_level = i_fb_div_out;
            end
            `SFL_MON_HIGH: begin
                mon_level = 1'b1;
            end
            `SFL_MON_REF: begin
                mon_level = i_ref_div_out;
            end
            `SFL_MON_LOCK_OD: begin
                mon_level = 1'b0;
                mon_oe = !i_lock_detect;
            end
            `SFL_MON_SDATA: begin
                mon_level = word_if.data_bit;
            end
            default: begin
                mon_level = 1'b0;
            end
        endcase
        st_nxt.monitor_out = mon_level;
        st_nxt.monitor_oe = mon_oe;
    end

    // Reset leaves the device powered down with counters held
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            st_r <= '0;
            st_r.power_down <= 1'b1;
            st_r.counter_hold <= 1'b1;
            st_r.timeout_load <= 1'b1;
            st_r.lock_reset <= 1'b1;
            st_r.pump_hiz <= 1'b1;
            st_r.monitor_oe <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state flops
    assign o_power_down = st_r.power_down;
    assign o_counter_hold = st_r.counter_hold;
    assign o_timeout_load = st_r.timeout_load;
    assign o_lock_reset = st_r.lock_reset;
    assign o_pump_hiz = st_r.pump_hiz;
    assign o_pump_current = st_r.pump_current;
    assign o_fast_lock = st_r.fast_lock;
    assign o_detector_sense = st_r.detector_sense;
    assign o_prescale_sel = st_r.prescale_sel;
    assign o_monitor_out = st_r.monitor_out;
    assign o_monitor_oe = st_r.monitor_oe;
    assign o_ref_latch = st_r.ref_w;
    assign o_fb_latch = st_r.fb_w;
endmodule

// ===== core/sfl_cfg.svh
// Field positions, codes and timing constants of the function control latch.
`ifndef SFL_CFG_SVH
`define SFL_CFG_SVH

`define SFL_WORD_W 24
`define SFL_SEL_HI 1
`define SFL_SEL_LO 0
`define SFL_SEL_REF 2'h0
`define SFL_SEL_FB 2'h1
`define SFL_SEL_FUNC 2'h2
`define SFL_CNT_CLEAR 2
`define SFL_SOFT_SLEEP 3
`define SFL_MON_LSB 4
`define SFL_MON_MSB 6
`define SFL_DET_SENSE 7
`define SFL_PUMP_HIZ 8
`define SFL_QS_ENABLE 9
`define SFL_QS_VARIANT 10
`define SFL_TO_LSB 11
`define SFL_TO_MSB 14
`define SFL_MAIN_LSB 15
`define SFL_MAIN_MSB 17
`define SFL_ALT_LSB 18
`define SFL_ALT_MSB 20
`define SFL_SPARE 21
`define SFL_PRE_LSB 22
`define SFL_PRE_MSB 23
`define SFL_BOOST 21
`define SFL_MON_LOW 3'h0
`define SFL_MON_LOCK 3'h1
`define SFL_MON_FB 3'h2
`define SFL_MON_HIGH 3'h3
`define SFL_MON_REF 3'h4
`define SFL_MON_LOCK_OD 3'h5
`define SFL_MON_SDATA 3'h6
`define SFL_TO_STEP 12'h004
`define SFL_TO_CNT_W 12

`endif

// ===== core/sfl_pkg.sv
// Types shared by the function latch control modules.
package sfl_pkg;
    typedef logic [23:0] sfl_word_type;
    typedef logic [11:0] sfl_count_type;
endpackage

// ===== core/sfl_word_if.sv
// Carrier of a completed serial word from the receiver to the latch logic.
`timescale 1ns/10ps
interface sfl_word_if;
    import sfl_pkg::*;
    sfl_word_type word;
    logic load;
    logic data_bit;
    modport src (output word, output load, output data_bit);
    modport dst (input word, input load, input data_bit);
endinterface

// ===== core/sfl_serial_rx.sv
// Three-wire serial receiver: synchronises pins, shifts 24 bits, emits a word on load.
`timescale 1ns/10ps
module sfl_serial_rx
    import sfl_pkg::*;
(
    input wire logic i_clk_sys, // System clock
    input wire logic i_reset, // Synchronous reset, active high
    input wire logic i_sclk, // Serial clock pin
    input wire logic i_sdata, // Serial data pin
    input wire logic i_load_strobe, // Load strobe pin
    sfl_word_if.src word_if // Completed word towards latches
);
    `include "sfl_cfg.svh"

    typedef struct packed {
        logic [2:0] sclk_s;
        logic [2:0] data_s;
        logic [2:0] load_s;
        sfl_word_type shift;
        sfl_word_type word;
        logic load;
    } sfl_rx_state_type;

    sfl_rx_state_type st_r;
    sfl_rx_state_type st_nxt;

    // Shift on serial clock rise, hand over on strobe rise
    always_comb begin
        st_nxt = st_r;
        st_nxt.sclk_s = {st_r.sclk_s[1:0], i_sclk};
        st_nxt.data_s = {st_r.data_s[1:0], i_sdata};
        st_nxt.load_s = {st_r.load_s[1:0], i_load_strobe};
        st_nxt.load = 1'b0;
        // Edge counts when stage two shows the new level and stage three still the old
        if (st_r.sclk_s[1] && !st_r.sclk_s[2]) begin
            st_nxt.shift = {st_r.shift[`SFL_WORD_W-2:0], st_r.data_s[2]};
        end
        // Keeps working in power-down; nothing here looks at it
        if (st_r.load_s[1] && !st_r.load_s[2]) begin
            st_nxt.word = st_r.shift;
            st_nxt.load = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign word_if.word = st_r.word;
    assign word_if.load = st_r.load;
    assign word_if.data_bit = st_r.data_s[2];
endmodule

// ===== sim/sfl_top_properties.sv
// Port-level checks of the function latch control.
`timescale 1ns/10ps
module sfl_top_properties
    import sfl_pkg::*;
(
    input wire logic i_clk_sys, // clk
    input wire logic i_reset, // rst
    input wire logic i_sclk, // pin
    input wire logic i_sdata, // pin
    input wire logic i_load_strobe, // pin
    input wire logic i_chip_on, // pin
    input wire logic i_pfd_tick, // tick
    input wire logic i_lock_detect, // mon
    input wire logic i_ref_div_out, // mon
    input wire logic i_fb_div_out, // mon
    input wire logic o_power_down, // out
    input wire logic o_counter_hold, // out
    input wire logic o_timeout_load, // out
    input wire logic o_lock_reset, // out
    input wire logic o_pump_hiz, // out
    input wire logic [2:0] o_pump_current, // out
    input wire logic o_fast_lock, // out
    input wire logic o_detector_sense, // out
    input wire logic [1:0] o_prescale_sel, // out
    input wire logic o_monitor_out, // out
    input wire logic o_monitor_oe, // out
    input wire sfl_word_type o_ref_latch, // out
    input wire sfl_word_type o_fb_latch // out
);
    // One domain only
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    AST_PD_PUMP: assert property (o_power_down |-> o_pump_hiz && o_lock_reset)
        else $error("pump or lock detect live in power-down");
    AST_PD_COUNT: assert property (o_power_down |-> o_counter_hold && o_timeout_load)
        else $error("counters not held in power-down");
    // Five samples cover the pin synchroniser plus the output flop
    AST_CHIP_OFF: assert property (!i_chip_on [*5] |-> o_power_down)
        else $error("chip-on low did not power down");
    AST_REF_SEL: assert property (o_ref_latch != 24'h0 |-> o_ref_latch[1:0] == 2'h0)
        else $error("reference latch took a foreign select");
    AST_FB_SEL: assert property (o_fb_latch != 24'h0 |-> o_fb_latch[1:0] == 2'h1)
        else $error("feedback latch took a foreign select");
    AST_REF_HOLD: assert property (!i_load_strobe [*8] |-> $stable(o_ref_latch))
        else $error("reference latch moved without a strobe");
    AST_CFG_HOLD: assert property (!i_load_strobe [*8] |-> $stable(o_prescale_sel))
        else $error("prescale select moved without a strobe");
    AST_CUR_HOLD: assert property (($stable(o_fast_lock) && !i_load_strobe) [*8]
        |-> $stable(o_pump_current)) else $error("pump current moved on its own");
    cover property ($rose(o_fast_lock));
    cover property ($fell(o_fast_lock) && !i_load_strobe);
    cover property ($rose(o_power_down));
endmodule
bind sfl_top sfl_top_properties u_props (.*);

// ===== sim/sfl_host_model.sv
// Host side of the three-wire link.
`timescale 1ns/10ps
module sfl_host_model (
    input wire logic i_clk_sys, // clk
    output logic o_sclk, // serial clock, stopped between frames
    output logic o_sdata, // serial data
    output logic o_load_strobe // load strobe
);
    initial begin
        o_sclk = 1'b0;
        o_sdata = 1'b0;
        o_load_strobe = 1'b0;
    end
    // One word at a 160 ns link clock, top bit first
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            @(negedge i_clk_sys) o_sdata = w[i];
            repeat (4) @(negedge i_clk_sys);
            o_sclk = 1'b1;
            repeat (8) @(negedge i_clk_sys);
            o_sclk = 1'b0;
            repeat (3) @(negedge i_clk_sys);
        end
        o_load_strobe = 1'b1;
        repeat (8) @(negedge i_clk_sys);
        o_load_strobe = 1'b0;
        o_sdata = ~o_sdata; // Released line shows no stale bit
        repeat (8) @(negedge i_clk_sys);
    endtask
endmodule

// ===== sim/sfl_top_tb.sv
// Self-checking bench of the function latch control.
`timescale 1ns/10ps
module sfl_top_tb;
    import sfl_pkg::*;
    logic i_clk_sys = 1'b0, i_reset = 1'b1, i_chip_on = 1'b1, i_pfd_tick = 1'b0;
    logic i_lock_detect = 1'b1, i_ref_div_out = 1'b0, i_fb_div_out = 1'b1;
    logic i_sclk, i_sdata, i_load_strobe, o_power_down, o_counter_hold, o_timeout_load;
    logic o_lock_reset, o_pump_hiz, o_fast_lock, o_detector_sense, o_monitor_out, o_monitor_oe;
    logic [2:0] o_pump_current;
    logic [1:0] o_prescale_sel;
    sfl_word_type o_ref_latch, o_fb_latch;
    int n_fail = 0, checked = 0, cyc = 0;
    sfl_top u_dut (.*);
    sfl_host_model u_host (.i_clk_sys(i_clk_sys), .o_sclk(i_sclk), .o_sdata(i_sdata),
        .o_load_strobe(i_load_strobe));
    always #5 i_clk_sys = ~i_clk_sys;
    // Detector tick every fourth cycle
    always @(negedge i_clk_sys) begin
        cyc <= cyc + 1;
        i_pfd_tick <= (cyc % 4 == 0);
    end
    // Function word; spare bit always zero, lo = variant,enable,hiz,sense,mon,sleep,clear
    function automatic sfl_word_type fw(input logic [2:0] alt, input logic [3:0] to,
        input logic [8:0] lo);
        return {2'h1, 1'b0, alt, 3'h3, to, lo, 2'h2};
    endfunction
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Counter-clear bracket around the counter loads
    task automatic t_load();
        u_host.send(fw(3'h5, 4'h0, 9'b0_0_0_1_011_0_1));
        chk(o_counter_hold, 1'b1);
        chk({o_prescale_sel, o_detector_sense, o_pump_hiz, o_pump_current}, 7'h33);
        u_host.send(24'h912344);
        chk(o_ref_latch, 24'h912344);
        u_host.send(24'h0abcd1);
        u_host.send(24'h5a5a5b);
        chk(o_fb_latch, 24'h0abcd1);
        chk(o_ref_latch, 24'h912344);
        u_host.send(fw(3'h5, 4'h0, 9'b0_0_1_0_011_0_0));
        chk({o_counter_hold, o_pump_hiz, o_detector_sense}, 3'h2);
        $display("load test done");
    endtask
    // Every source at both levels; code 6 shows the inverted idle data line
    task automatic t_monitor();
        logic e;
        for (int c = 0; c < 8; c++) begin
            for (int v = 0; v < 2; v++) begin
                {i_lock_detect, i_ref_div_out, i_fb_div_out} = {3{v[0]}};
                u_host.send(fw(3'h5, 4'h0, {4'h0, c[2:0], 2'h0}));
                e = (c == 3 || c == 6) || (v == 1 && (c == 1 || c == 2 || c == 4));
                chk(o_monitor_out, e);
                chk(o_monitor_oe, c != 5 || v == 0);
            end
        end
        $display("monitor test done");
    endtask
    task automatic t_sleep();
        u_host.send(fw(3'h5, 4'h0, 9'b0_0_0_0_011_1_0));
        chk({o_power_down, o_pump_hiz, o_counter_hold, o_timeout_load}, 4'hf);
        u_host.send(24'h123450);
        chk(o_ref_latch, 24'h123450);
        u_host.send(fw(3'h5, 4'h0, 9'b0_0_0_0_011_0_0));
        chk(o_power_down, 1'b0);
        $display("sleep test done");
    endtask
    task automatic t_chip_on();
        i_chip_on = 1'b0;
        repeat (8) @(negedge i_clk_sys);
        chk({o_power_down, o_lock_reset}, 2'h3);
        u_host.send(24'h012341);
        chk(o_fb_latch, 24'h012341);
        i_chip_on = 1'b1;
        repeat (8) @(negedge i_clk_sys);
        chk({o_power_down, o_ref_latch}, {1'b0, 24'h123450});
        $display("chip-on test done");
    endtask
    // Mode one holds boost however long; disabled enable ignores boost
    task automatic t_fast_one();
        u_host.send(fw(3'h5, 4'h0, 9'b0_1_0_0_011_0_0));
        u_host.send(24'h200001);
        repeat (200) @(negedge i_clk_sys);
        chk({o_fast_lock, o_pump_current}, 4'hd);
        u_host.send(24'h000001);
        chk({o_fast_lock, o_pump_current}, 4'h3);
        u_host.send(fw(3'h5, 4'h0, 9'b0_0_0_0_011_0_0));
        u_host.send(24'h200001);
        chk({o_fast_lock, o_pump_current}, 4'h3);
        $display("fast lock one test done");
    endtask
    // Code 2 gives twelve ticks: on at seven, off by fifteen
    task automatic t_fast_two();
        u_host.send(fw(3'h5, 4'h2, 9'b1_1_0_0_011_0_0));
        u_host.send(24'h123450);
        u_host.send(24'h200001);
        repeat (16) @(negedge i_clk_sys);
        chk({o_fast_lock, o_pump_current}, 4'hd);
        repeat (32) @(negedge i_clk_sys);
        chk({o_fast_lock, o_pump_current, o_fb_latch}, {4'h3, 24'h000001});
        $display("fast lock two test done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge i_clk_sys);
        chk({o_power_down, o_pump_hiz, o_ref_latch}, {2'h3, 24'h0});
        i_reset = 1'b0;
        repeat (8) @(negedge i_clk_sys);
        t_load();
        t_monitor();
        t_sleep();
        t_chip_on();
        t_fast_one();
        t_fast_two();
        final_report();
    end
    // Hang guard
    initial begin
        repeat (100000) @(negedge i_clk_sys);
        n_fail++;
        final_report();
    end
endmodule
